// [rdc_pkg.sv]
// Purpose: Shared constants and types for the receive DMA commit block.
// Assumes: APB register indices; byte address is four times the index.
// Notes: Own control bits are gathered in the config and event registers.
package rdc_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] SOF_IDX = 8'h26;   // Start-of-frame offset
    localparam logic [7:0] FCNT_IDX = 8'h28;  // Frame count, clears on read
    localparam logic [7:0] BCNT_IDX = 8'h2a;  // Byte count, clears on read
    localparam logic [7:0] CFG_IDX = 8'h40;   // Mode and bus control bits
    localparam logic [7:0] BUFEV_IDX = 8'h41; // Buffer event view
    localparam logic [7:0] MISS_IDX = 8'h42;  // Missed frame counter
    // ----------------------------------------
    // Config register fields
    // ----------------------------------------
    localparam int IRQ_EN_BIT = 0;     // Frame-done interrupt enable
    localparam int DMA_RESET_BIT = 6;  // Reset-DMA command, write only
    localparam int STREAM_BIT = 7;     // Stream mode
    localparam int DMA_ONLY_BIT = 9;   // DMA for every frame
    localparam int AUTO_BIT = 10;      // Auto-switch enable
    localparam int SIZE_BIT = 13;      // Host buffer 64K when set
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WMASK = 16'h2681;
    // ----------------------------------------
    // Event register fields and sizes
    // ----------------------------------------
    localparam int FLAG_BIT = 7;       // Frame-done flag
    localparam int MODE_BIT = 0;       // In DMA mode
    localparam int BUSY_BIT = 1;       // Frame transfer in progress
    localparam int COMMIT_BIT = 2;     // Host space committed
    localparam int FCNT_W = 12;
    localparam logic [15:0] MASK_16K = 16'h3fff;
    localparam logic [15:0] MASK_64K = 16'hffff;
    localparam logic [16:0] HDR_BYTES = 17'h00004;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        MD_MEM = 3'b001,
        MD_WAIT = 3'b010,
        MD_DMA = 3'b100
    } rdc_mode_type;
    typedef enum logic [2:0] {
        MV_IDLE = 3'b001,
        MV_MOVE = 3'b010,
        MV_DONE = 3'b100
    } rdc_move_type;
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] len;
    } rdc_frame_type;
endpackage

// [rdc_frame_mover.sv]
// Purpose: Moves one held frame as 16-bit words to the host buffer.
// Assumes: Held data word is valid until popped; ack is active low.
// Notes: One word every second cycle so the pop is seen before reuse.
`timescale 1ns/1ps
module rdc_frame_mover
    import rdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Frame to move
    input wire logic start_i,
    input wire rdc_frame_type frame_i,
    input wire logic [15:0] base_i,
    input wire logic [15:0] mask_i,
    input wire logic [15:0] data_i,
    output logic data_rd_o,
    // Host DMA side
    output logic dma_req_o,
    input wire logic dma_ack_n_i,
    output logic wr_valid_o,
    output logic [15:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    // Status
    output logic done_o,
    output logic busy_o
);
    rdc_move_type state_q;       // Mover state
    rdc_frame_type frame_q;      // Latched header
    logic [15:0] base_q;         // Frame start offset
    logic [15:0] idx_q;          // Word index
    logic [15:0] last_q;         // Index of final word
    logic emit;                  // A word goes out now

    assign emit = (state_q == MV_MOVE) && !dma_ack_n_i && !wr_valid_o;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Request stays high for the whole frame; header words go first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= MV_IDLE;
            dma_req_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            idx_q <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                MV_IDLE: begin
                    if (start_i) begin
                        state_q <= MV_MOVE;
                        dma_req_o <= 1'b1;
                        busy_o <= 1'b1;
                        idx_q <= 16'h0000;
                    end
                end
                MV_MOVE: begin
                    if (emit) begin
                        idx_q <= idx_q + 16'h0001;
                        if (idx_q == last_q) begin
                            state_q <= MV_DONE;
                            dma_req_o <= 1'b0;
                        end
                    end
                end
                MV_DONE: begin
                    state_q <= MV_IDLE;
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                default: begin
                    state_q <= MV_IDLE;
                end
            endcase
        end
    end

    // Latch the frame header and base at the start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_q <= '0;
            base_q <= 16'h0000;
            last_q <= 16'h0000;
        end else if (start_i && state_q == MV_IDLE) begin
            frame_q <= frame_i;
            base_q <= base_i;
            // Status, length, then data rounded up to whole words
            last_q <= 16'((17'(frame_i.len) + 17'h00001) >> 1) + 16'h0001;
        end
    end

    // ----------------------------------------
    // Word output
    // ----------------------------------------
    // Words land at even offsets, wrapped at the buffer size
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_valid_o <= 1'b0;
            wr_addr_o <= 16'h0000;
            wr_data_o <= 16'h0000;
            data_rd_o <= 1'b0;
        end else begin
            wr_valid_o <= emit;
            data_rd_o <= emit && (idx_q > 16'h0001);
            if (emit) begin
                wr_addr_o <= (base_q + {idx_q[14:0], 1'b0}) & mask_i;
                if (idx_q == 16'h0000) begin
                    wr_data_o <= frame_q.status;
                end else if (idx_q == 16'h0001) begin
                    wr_data_o <= frame_q.len;
                end else begin
                    wr_data_o <= data_i;
                end
            end
        end
    end
endmodule

// [rdc_rx_dma.sv]
// Purpose: Receive slave DMA with host buffer commit and auto-switch.
// Assumes: On-chip buffer presents the oldest complete accepted frame.
// Notes: APB answers in one access cycle; outputs are registered.
// Operation
// - Commit only transferred frames on count read
// - Never write into committed host space
// - Second count read releases committed space
// - Event read with flag and new frames skips
// - Reset-DMA command releases committed space
// - Word writes, frames aligned to 32 bits
// - Start register holds latest frame offset
// - Flag set on nonzero count, cleared at zero
// - Event register read leaves flag alone
// - DMA-only moves complete filtered frames, 16K/64K
// - Auto-switch needs auto bit, not DMA-only
// - Both bits set means DMA always
// - Enough space at start means normal buffering
// - Short space: discard on filter fail, else switch
// - Oldest uncommitted held frame moves first
// - Drop pending receive events when DMA begins
// - No switch while on-chip frame committed
// - After frame, update registers, flag, interrupt
// - Lost frame bumps miss counter, clears events
// - Leave DMA after queue, zero read, idle
// - Request high, ack low, header then data
// - Count in low 12 bits, upper zero
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module rdc_rx_dma
    import rdc_pkg::*;
#(
    parameter int APB_AW = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Receive front end
    input wire logic rx_frame_start_i,
    input wire logic rx_da_pass_i,
    input wire logic rx_space_ok_i,
    input wire logic onchip_commit_i,
    input wire logic rx_missed_i,
    input wire logic stream_end_i,
    input wire logic isq_empty_i,
    output logic rx_discard_o,
    output logic isq_drop_rx_o,
    output logic event_clear_o,
    // On-chip held frames
    input wire logic held_valid_i,
    input wire rdc_frame_type held_frame_i,
    input wire logic [15:0] held_data_i,
    output logic held_data_rd_o,
    output logic held_release_o,
    // Host DMA
    output logic dma_req_o,
    input wire logic dma_ack_n_i,
    output logic host_wr_valid_o,
    output logic [15:0] host_wr_addr_o,
    output logic [15:0] host_wr_data_o,
    // Status
    output logic dma_frame_irq_o,
    output logic dma_mode_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    rdc_mode_type mode_q;        // Memory, waiting or DMA
    logic [15:0] cfg_q;          // Mode and control bits
    logic [15:0] sof_q;          // Latest frame start
    logic [FCNT_W-1:0] fcnt_q;   // Frames since last read
    logic [15:0] bcnt_q;         // Bytes since last read
    logic [15:0] miss_q;         // Missed frames
    logic flag_q;                // Frame-done flag
    logic [15:0] wr_ptr_q;       // Next frame offset
    logic [15:0] mark_q;         // End of last reported frames
    logic [15:0] cbase_q;        // Start of committed region
    logic commit_q;              // Committed region held
    logic zero_seen_q;           // Host read a zero count
    logic start_q;               // Start pulse to mover
    logic [16:0] foot_q;         // Host bytes of frame in flight
    logic [15:0] len_q;          // Length of frame in flight
    logic irq_q;                 // Interrupt pulse
    logic rdy_q;                 // APB ready
    logic err_q;                 // APB error
    logic [31:0] rdata_q;        // APB read data
    logic discard_q;             // Discard pulse
    logic drop_q;                // Queue drop pulse
    logic clr_q;                 // Event clear pulse
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [7:0] idx;             // Register index
    logic hit;                   // Mapped address
    logic acc;                   // Access phase edge
    logic rd_fcnt;               // Frame count read
    logic rd_bcnt;               // Byte count read
    logic rd_bufev;              // Event register read
    logic wr_cfg;                // Config write
    logic dma_reset;             // Reset-DMA command
    logic auto_on;               // Auto-switch active
    logic dma_only;              // DMA for all frames
    logic [15:0] mask;           // Buffer wrap mask
    logic [16:0] foot_new;       // Host bytes of next frame
    logic [15:0] room;           // Free bytes before commit
    logic fits;                  // Next frame fits
    logic mv_done;               // Mover finished
    logic mv_busy;               // Mover running
    logic release_c;             // Commit released now
    logic flag_set;              // Flag set event

    assign idx = paddr_i[9:2];
    assign hit = (paddr_i[1:0] == 2'b00) && (paddr_i[APB_AW-1:10] == '0)
        && (idx == SOF_IDX || idx == FCNT_IDX || idx == BCNT_IDX
        || idx == CFG_IDX || idx == BUFEV_IDX || idx == MISS_IDX);
    assign acc = psel_i && penable_i && rdy_q;
    assign rd_fcnt = acc && !pwrite_i && hit && idx == FCNT_IDX;
    assign rd_bcnt = acc && !pwrite_i && hit && idx == BCNT_IDX;
    assign rd_bufev = acc && !pwrite_i && hit && idx == BUFEV_IDX;
    assign wr_cfg = acc && pwrite_i && hit && idx == CFG_IDX;
    assign dma_reset = wr_cfg && pwdata_i[DMA_RESET_BIT];
    assign dma_only = cfg_q[DMA_ONLY_BIT];
    assign auto_on = cfg_q[AUTO_BIT] && !dma_only;
    assign mask = cfg_q[SIZE_BIT] ? MASK_64K : MASK_16K;

    // Host footprint: header plus data padded to a 32-bit boundary
    assign foot_new = HDR_BYTES + ((17'(held_frame_i.len) + 17'h00003) & 17'h1fffc);
    assign room = (cbase_q - wr_ptr_q) & mask;
    // Writes stop short of the committed region
    assign fits = !commit_q || (room != 16'h0000 && foot_new <= {1'b0, room});

    // Every count read drops the old commitment; skip and reset do too
    assign release_c = rd_fcnt
        || (rd_bufev && flag_q && fcnt_q != '0)
        || dma_reset;

    // Stream mode sets the flag only at the end of a stream cycle
    assign flag_set = cfg_q[STREAM_BIT] ? stream_end_i : mv_done;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Ready rises in the first access cycle; data is latched at setup
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            rdy_q <= psel_i && !penable_i;
            err_q <= psel_i && !penable_i && !hit;
            if (psel_i && !penable_i) begin
                case (idx)
                    SOF_IDX: rdata_q <= {16'h0000, sof_q};
                    FCNT_IDX: rdata_q <= {20'h00000, fcnt_q};
                    BCNT_IDX: rdata_q <= {16'h0000, bcnt_q};
                    CFG_IDX: rdata_q <= {16'h0000, cfg_q};
                    BUFEV_IDX: rdata_q <= {24'h000000, flag_q, 4'h0, commit_q, mv_busy,
                        mode_q == MD_DMA};
                    MISS_IDX: rdata_q <= {16'h0000, miss_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Config register; the reset command bit is not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= pwdata_i[15:0] & CFG_WMASK;
        end
    end

    // ----------------------------------------
    // Mode control
    // ----------------------------------------
    // Switch into DMA only on need; leave once the host is caught up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MD_MEM;
            discard_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            discard_q <= 1'b0;
            drop_q <= 1'b0;
            case (mode_q)
                MD_MEM: begin
                    if (dma_only) begin
                        mode_q <= MD_DMA;
                        drop_q <= 1'b1;
                    end else if (auto_on && rx_frame_start_i && !rx_space_ok_i) begin
                        if (!rx_da_pass_i) begin
                            discard_q <= 1'b1;
                        end else if (onchip_commit_i) begin
                            mode_q <= MD_WAIT;
                        end else begin
                            mode_q <= MD_DMA;
                            drop_q <= 1'b1;
                        end
                    end
                end
                MD_WAIT: begin
                    // Hold off until the on-chip commitment ends or DMA-only is set
                    if (dma_only || !onchip_commit_i) begin
                        mode_q <= MD_DMA;
                        drop_q <= 1'b1;
                    end
                end
                MD_DMA: begin
                    if (!dma_only && isq_empty_i && zero_seen_q && !mv_busy && !start_q) begin
                        mode_q <= MD_MEM;
                    end
                end
                default: begin
                    mode_q <= MD_MEM;
                end
            endcase
        end
    end

    // Host must read a zero count after the last frame moved
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_seen_q <= 1'b0;
        end else if (mv_done || drop_q) begin
            zero_seen_q <= 1'b0;
        end else if (rd_fcnt) begin
            zero_seen_q <= (fcnt_q == '0);
        end
    end

    // ----------------------------------------
    // Frame launch
    // ----------------------------------------
    // Oldest held frame starts once the mover is idle and it fits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
            foot_q <= 17'h00000;
            len_q <= 16'h0000;
        end else begin
            start_q <= 1'b0;
            if (mode_q == MD_DMA && held_valid_i && !mv_busy && !start_q && !mv_done && fits) begin
                start_q <= 1'b1;
                foot_q <= foot_new;
                len_q <= held_frame_i.len;
            end
        end
    end

    rdc_frame_mover u_mover (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_q),
        .frame_i(held_frame_i),
        .base_i(wr_ptr_q),
        .mask_i(mask),
        .data_i(held_data_i),
        .data_rd_o(held_data_rd_o),
        .dma_req_o(dma_req_o),
        .dma_ack_n_i(dma_ack_n_i),
        .wr_valid_o(host_wr_valid_o),
        .wr_addr_o(host_wr_addr_o),
        .wr_data_o(host_wr_data_o),
        .done_o(mv_done),
        .busy_o(mv_busy)
    );

    // ----------------------------------------
    // Pointers and commitment
    // ----------------------------------------
    // Pointer wraps at the buffer size after each whole frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= 16'h0000;
            sof_q <= 16'h0000;
        end else if (mv_done) begin
            wr_ptr_q <= (wr_ptr_q + foot_q[15:0]) & mask;
            sof_q <= wr_ptr_q;
        end
    end

    // A count read commits the frames it reports and frees the old ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            commit_q <= 1'b0;
            cbase_q <= 16'h0000;
            mark_q <= 16'h0000;
        end else begin
            if (release_c) begin
                commit_q <= 1'b0;
            end
            if (rd_fcnt && fcnt_q != '0) begin
                commit_q <= 1'b1;
                cbase_q <= mark_q;
            end
            if (rd_fcnt || dma_reset) begin
                mark_q <= wr_ptr_q;
            end
        end
    end

    // ----------------------------------------
    // Counts and flag
    // ----------------------------------------
    // A frame finishing during a read is counted after the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fcnt_q <= '0;
            bcnt_q <= 16'h0000;
        end else begin
            if (rd_fcnt) begin
                fcnt_q <= mv_done ? FCNT_W'(1) : '0;
            end else if (mv_done) begin
                fcnt_q <= fcnt_q + FCNT_W'(1);
            end
            if (rd_bcnt) begin
                bcnt_q <= mv_done ? len_q : 16'h0000;
            end else if (mv_done) begin
                bcnt_q <= bcnt_q + len_q;
            end
        end
    end

    // Set wins; reads of the event register never touch the flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (flag_set) begin
            flag_q <= 1'b1;
        end else if (fcnt_q == '0) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt pulse follows each flag set when enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_set && cfg_q[IRQ_EN_BIT];
        end
    end

    // ----------------------------------------
    // Missed frames
    // ----------------------------------------
    // Lost frames are counted and their event reports dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miss_q <= 16'h0000;
            clr_q <= 1'b0;
        end else begin
            clr_q <= rx_missed_i;
            if (rx_missed_i) begin
                miss_q <= miss_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata_o = rdata_q;
    assign pready_o = rdy_q;
    assign pslverr_o = err_q;
    assign rx_discard_o = discard_q;
    assign isq_drop_rx_o = drop_q;
    assign event_clear_o = clr_q;
    assign held_release_o = mv_done;
    assign dma_frame_irq_o = irq_q;
    assign dma_mode_o = mode_q[2]; // One-hot DMA state bit
endmodule

// [rdc_assertions.sv]
// Purpose: Port checks for rdc_rx_dma.
// Assumes: Zero-wait APB, registered outputs.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
module rdc_assertions (
    // Clock, reset, APB
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Frame path
    input wire logic rx_missed_i,
    input wire logic event_clear_o,
    input wire logic dma_req_o,
    input wire logic dma_ack_n_i,
    input wire logic host_wr_valid_o,
    input wire logic [15:0] host_wr_addr_o,
    input wire logic held_release_o,
    input wire logic dma_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_apb_answer: assert property (psel_i && !penable_i |=> pready_o) else $error("pready late");
    a_apb_pulse: assert property (pready_o |=> !pready_o) else $error("pready held");
    a_err_ready: assert property (pslverr_o |-> pready_o) else $error("lone pslverr");
    a_word_ack: assert property (host_wr_valid_o |-> !$past(dma_ack_n_i)) else $error("no ack");
    a_word_gap: assert property (host_wr_valid_o |=> !host_wr_valid_o) else $error("words too close");
    a_word_even: assert property (host_wr_valid_o |-> !host_wr_addr_o[0]) else $error("odd address");
    a_miss_clear: assert property (rx_missed_i |=> event_clear_o) else $error("no clear");
    a_frame_done: assert property ($fell(dma_req_o) |-> ##[0:4] held_release_o) else $error("no release");
    a_req_mode: assert property ($rose(dma_req_o) |-> dma_mode_o) else $error("req outside mode");
    cover property (host_wr_valid_o);
    cover property (pslverr_o);
    cover property (held_release_o);
endmodule

// [rdc_host_dma_model.sv]
// Purpose: Host DMA controller stand-in.
// Assumes: Grant delay set by the bench.
// Notes: Ack withdrawn at the first clock edge that sees request low.
`timescale 1ns/1ps
module rdc_host_dma_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Handshake
    input wire logic dma_req_i,
    input wire logic [3:0] delay_i,
    output logic dma_ack_n_o
);
    logic [3:0] wait_q; // Cycles since request
    // Grant after delay_i cycles, prompt or slow
    always_ff @(posedge clk_i) begin
        if (rst_i || !dma_req_i) begin
            wait_q <= 4'h0;
            dma_ack_n_o <= 1'b1;
        end else if (wait_q >= delay_i) begin
            dma_ack_n_o <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// [rdc_rx_dma_tb_top.sv]
// Purpose: Self-checking bench for rdc_rx_dma.
// Assumes: DMA-only mode, small random frames.
// Notes: Expectations queued, monitors compare.
`timescale 1ns/1ps
module rdc_rx_dma_tb_top import rdc_pkg::*; ;
    logic clk_i = 0;
    logic rst_i = 1;
    logic psel_i = 0;
    logic penable_i = 0;
    logic pwrite_i = 0;
    logic rx_missed_i = 0;
    logic held_valid_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0;
    logic [31:0] prdata_o;
    logic [5:0] fe_q = 0; // Front-end noise
    logic [3:0] delay_q = 0; // Grant delay
    logic [15:0] held_data_i = 0;
    rdc_frame_type held_frame_i = '0;
    logic pready_o, pslverr_o, dma_req_o, dma_ack_n_i, host_wr_valid_o, held_release_o;
    logic [15:0] host_wr_addr_o, host_wr_data_o;
    logic [32:0] rd_q[$]; // Expected reads
    logic [31:0] wr_q[$]; // Expected host words
    int err_count = 0;
    int total_checks = 0;
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) fe_q <= 6'($urandom);
    rdc_rx_dma u_rdc_rx_dma (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .rx_frame_start_i(fe_q[0]), .rx_da_pass_i(fe_q[1]),
        .rx_space_ok_i(fe_q[2]), .onchip_commit_i(fe_q[3]), .rx_missed_i, .stream_end_i(fe_q[4]),
        .isq_empty_i(fe_q[5]), .rx_discard_o(), .isq_drop_rx_o(), .event_clear_o(), .held_valid_i,
        .held_frame_i, .held_data_i, .held_data_rd_o(), .held_release_o, .dma_req_o, .dma_ack_n_i,
        .host_wr_valid_o, .host_wr_addr_o, .host_wr_data_o, .dma_frame_irq_o(), .dma_mode_o());
    rdc_host_dma_model u_rdc_host_dma_model (.clk_i, .rst_i, .dma_req_i(dma_req_o),
        .delay_i(delay_q), .dma_ack_n_o(dma_ack_n_i));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check({1'b0, got}, {1'b0, exp});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // APB transfer; reads queue their expected {pslverr, prdata}
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [15:0] d, input logic [32:0] exp);
        int n;
        if (!wr) rd_q.push_back(exp);
        paddr_i <= {2'b00, idx, 2'b00};
        pwrite_i <= wr;
        pwdata_i <= {16'h0000, d};
        psel_i <= 1;
        @(posedge clk_i) penable_i <= 1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin err_count++; give_verdict(); end
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clk_i);
    endtask
    // One held frame; base advances to the next aligned slot
    task automatic frame(inout logic [15:0] base);
        logic [15:0] len, st, dat;
        int n;
        len = 16'(1 + $urandom % 9);
        st = 16'($urandom);
        dat = 16'($urandom);
        wr_q.push_back({base, st});
        wr_q.push_back({base + 16'h2, len});
        for (n = 0; n < (len + 1) / 2; n++) wr_q.push_back({base + 16'(4 + 2 * n), dat});
        held_frame_i <= {st, len};
        held_data_i <= dat;
        delay_q <= 4'($urandom);
        held_valid_i <= 1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (held_release_o !== 1'b1 && n < 300);
        if (held_release_o !== 1'b1) begin err_count++; give_verdict(); end
        held_valid_i <= 0;
        @(posedge clk_i);
        base = (base + 16'h7 + len) & 16'hfffc;
    endtask
    always @(posedge clk_i) begin
        if (pready_o === 1'b1 && !pwrite_i) check({pslverr_o, prdata_o}, rd_q.pop_front());
        if (host_wr_valid_o === 1'b1) check_word({host_wr_addr_o, host_wr_data_o}, wr_q.pop_front());
    end
    initial begin
        logic [15:0] base, sof;
        void'($urandom(38));
        base = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        apb(CFG_IDX, 1, 16'h0601, 0);
        apb(8'h3f, 0, 0, {1'b1, 32'h0}); // unmapped
        frame(base);
        frame(base);
        apb(BUFEV_IDX, 0, 0, 33'h81);
        apb(BUFEV_IDX, 0, 0, 33'h81);
        apb(FCNT_IDX, 0, 0, 33'h2);
        apb(CFG_IDX, 1, 16'h0641, 0);
        apb(BUFEV_IDX, 0, 0, 33'h1);
        sof = base;
        frame(base);
        apb(FCNT_IDX, 0, 0, 33'h1);
        apb(FCNT_IDX, 0, 0, 33'h0);
        apb(BUFEV_IDX, 0, 0, 33'h1);
        apb(SOF_IDX, 0, 0, {17'h0, sof});
        rx_missed_i <= 1;
        @(posedge clk_i) rx_missed_i <= 0;
        apb(MISS_IDX, 0, 0, 33'h1);
        give_verdict();
    end
endmodule
bind rdc_rx_dma rdc_assertions u_rdc_assertions (.clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
    .rx_missed_i, .event_clear_o, .dma_req_o, .dma_ack_n_i, .host_wr_valid_o, .host_wr_addr_o,
    .held_release_o, .dma_mode_o);
